// >>> csc_pkg.sv
package csc_pkg;
  // configuration register offsets (byte addresses)
  localparam logic [11:0] CSC_OFF_CTRL   = 12'h000;
  localparam logic [11:0] CSC_OFF_PERIOD = 12'h004;
  localparam logic [11:0] CSC_OFF_MULT   = 12'h008;
  localparam logic [11:0] CSC_OFF_HOLD   = 12'h00c;
  localparam logic [11:0] CSC_OFF_OPT    = 12'h010;
  localparam logic [11:0] CSC_OFF_STATUS = 12'h014;
  localparam logic [11:0] CSC_OFF_CMD    = 12'h018;

  // ctrl fields
  localparam int CSC_CTRL_MODE_LSB = 0;
  localparam int CSC_CTRL_MODE_W   = 3;
  localparam int CSC_CTRL_FLOW_BIT = 4;

  // mode select codes
  localparam logic [2:0] CSC_MODE_CYCLIC     = 3'h4;
  localparam logic [2:0] CSC_MODE_CYCLIC_PIN = 3'h5;

  // option bits
  localparam int CSC_OPT_FULL_WAKE = 1;
  localparam int CSC_OPT_EXTENDED  = 2;

  // period limits in ticks, multiplier minimum
  localparam logic [11:0] CSC_PERIOD_MIN = 12'h020;
  localparam logic [11:0] CSC_PERIOD_MAX = 12'haf0;
  localparam logic [15:0] CSC_MULT_MIN   = 16'h0001;

  // reset values
  localparam logic [11:0] CSC_PERIOD_RST = 12'h020;
  localparam logic [15:0] CSC_MULT_RST   = 16'h0001;
  localparam logic [15:0] CSC_HOLD_RST   = 16'h00c8;
  localparam logic [7:0]  CSC_OPT_RST    = 8'h00;
  localparam logic [7:0]  CSC_CTRL_RST   = 8'h00;

  // timing
  localparam int CSC_CLK_HZ     = 100_000_000;
  localparam int CSC_TICK_MS    = 10;
  localparam int CSC_POLL_MS    = 100;
  localparam int CSC_TICK_CYC   = CSC_CLK_HZ / 1000 * CSC_TICK_MS;
  localparam int CSC_POLL_TICKS = CSC_POLL_MS / CSC_TICK_MS;

  // cmd bit
  localparam int CSC_CMD_SLEEP_NOW = 0;

  typedef enum logic [1:0] {
    CSC_ST_SLEEP = 2'b00,
    CSC_ST_POLL  = 2'b01,
    CSC_ST_AWAKE = 2'b11
  } csc_state_type;
endpackage

// >>> csc_sleep_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - data while awake starts wake-hold timer
// - each new data reloads wake-hold timer
// - poll parent every 100 ms while awake
// - sleep on hold expiry or sleep-now
// - period accepts 0x20 to 0xaf0 ticks
// - multiplier accepts 1 to 0xffff
// - option 0x02 holds full wake time
// - option 0x04 sleeps period times multiplier
// - short sleep lasts one period
// - poll after period, pending data holds awake
// - multiplier 1 raises indicator every wake
// - multiplier above 1 wakes host every nth short-sleep wake, every wake in extended sleep
// - radio data while awake raises indicator at once
// - extended sleep is period times multiplier
// - pin falling edge wakes, holds wake time
// - indicator high awake, clear-to-send low awake
module csc_sleep_ctrl #(
  parameter int TICK_CYC = csc_pkg::CSC_TICK_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        sleep_request_pin_in,
  input  wire logic        serial_data_in,
  input  wire logic        radio_data_in,
  input  wire logic        poll_ack_in,
  input  wire logic        poll_pending_in,
  output logic             poll_req_out,
  output logic             awake_ind_out,
  output logic             cts_n_out
);
  import csc_pkg::*;

  if (TICK_CYC < 2) begin : g_tick_check
    $error("tick count too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]    ctrl_q;
  logic [11:0]   period_q;
  logic [15:0]   mult_q;
  logic [15:0]   hold_q;
  logic [7:0]    opt_q;
  logic          sleep_now_q;
  csc_state_type state_q;
  logic          pready_q;
  logic [31:0]   prdata_q;
  logic          pslverr_q;

  wire           apb_setup = psel_in & ~penable_in;
  wire           apb_wr    = psel_in & penable_in & pwrite_in & pready_q;
  wire [2:0]     mode      = ctrl_q[CSC_CTRL_MODE_LSB +: CSC_CTRL_MODE_W];
  wire           cyclic    = (mode == CSC_MODE_CYCLIC) | (mode == CSC_MODE_CYCLIC_PIN);
  wire           addr_ok   = (paddr_in[1:0] == 2'h0) & (paddr_in <= CSC_OFF_CMD);

  // no wait state: ready rises the cycle after setup
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~addr_ok;
      if (apb_setup) begin
        case (paddr_in)
          CSC_OFF_CTRL:   prdata_q <= {24'h0, ctrl_q};
          CSC_OFF_PERIOD: prdata_q <= {20'h0, period_q};
          CSC_OFF_MULT:   prdata_q <= {16'h0, mult_q};
          CSC_OFF_HOLD:   prdata_q <= {16'h0, hold_q};
          CSC_OFF_OPT:    prdata_q <= {24'h0, opt_q};
          CSC_OFF_STATUS: prdata_q <= {28'h0, awake_ind_out, 1'b0, state_q};
          default:        prdata_q <= 32'h0;
        endcase
      end else begin
        prdata_q <= 32'h0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_q      <= CSC_CTRL_RST;
      period_q    <= CSC_PERIOD_RST;
      mult_q      <= CSC_MULT_RST;
      hold_q      <= CSC_HOLD_RST;
      opt_q       <= CSC_OPT_RST;
      sleep_now_q <= 1'b0;
    end else begin
      sleep_now_q <= 1'b0;
      if (apb_wr) begin
        case (paddr_in)
          CSC_OFF_CTRL:   ctrl_q <= pwdata_in[7:0];
          CSC_OFF_PERIOD:
            // out-of-range writes are ignored so the period stays legal
            if (pwdata_in[31:12] == 20'h0 && pwdata_in[11:0] >= CSC_PERIOD_MIN
                && pwdata_in[11:0] <= CSC_PERIOD_MAX) begin
              period_q <= pwdata_in[11:0];
            end
          CSC_OFF_MULT:
            if (pwdata_in[15:0] >= CSC_MULT_MIN) begin
              mult_q <= pwdata_in[15:0];
            end
          CSC_OFF_HOLD:   hold_q <= pwdata_in[15:0];
          CSC_OFF_OPT:    opt_q <= pwdata_in[7:0];
          CSC_OFF_CMD:    sleep_now_q <= pwdata_in[CSC_CMD_SLEEP_NOW];
          default:        ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] pin_sync_q, ser_sync_q, rad_sync_q, ack_sync_q, pend_sync_q;
  logic       pin_prev_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_sync_q  <= 2'h0;
      ser_sync_q  <= 2'h0;
      rad_sync_q  <= 2'h0;
      ack_sync_q  <= 2'h0;
      pend_sync_q <= 2'h0;
      pin_prev_q  <= 1'b0;
    end else begin
      pin_sync_q  <= {pin_sync_q[0], sleep_request_pin_in};
      ser_sync_q  <= {ser_sync_q[0], serial_data_in};
      rad_sync_q  <= {rad_sync_q[0], radio_data_in};
      ack_sync_q  <= {ack_sync_q[0], poll_ack_in};
      pend_sync_q <= {pend_sync_q[0], poll_pending_in};
      pin_prev_q  <= pin_sync_q[1];
    end
  end
  wire pin_fall = pin_prev_q & ~pin_sync_q[1];
  wire data_in  = ser_sync_q[1] | rad_sync_q[1];
  wire radio    = rad_sync_q[1];
  wire ack      = ack_sync_q[1];
  wire pending  = pend_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // 10 ms tick
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
      if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
        tick_cnt_q <= 32'h0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [11:0] per_cnt_q;
  logic [15:0] mult_cnt_q;
  logic [15:0] wake_cnt_q;
  logic [15:0] hold_cnt_q;
  logic [7:0]  poll_cnt_q;
  logic        poll_q;
  logic        ind_q;
  logic        hold_run_q;

  wire ext       = opt_q[CSC_OPT_EXTENDED];
  wire full_wake = opt_q[CSC_OPT_FULL_WAKE];
  wire per_done  = tick_q & (per_cnt_q >= period_q - 12'h1);
  wire ext_done  = per_done & (mult_cnt_q >= mult_q - 16'h1);
  wire sleep_done = ext ? ext_done : per_done;
  wire wake_pin  = (mode == CSC_MODE_CYCLIC_PIN) & pin_fall;
  wire hold_exp  = hold_run_q & tick_q & (hold_cnt_q <= 16'h1);
  // host is woken every wake with multiplier 1 or extended sleep, else on the nth wake
  wire host_wake = (mult_q == CSC_MULT_MIN) | ext | (wake_cnt_q >= mult_q - 16'h1);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q    <= CSC_ST_SLEEP;
      per_cnt_q  <= 12'h0;
      mult_cnt_q <= 16'h0;
      wake_cnt_q <= 16'h0;
      hold_cnt_q <= 16'h0;
      hold_run_q <= 1'b0;
      poll_cnt_q <= 8'h0;
      poll_q     <= 1'b0;
      ind_q      <= 1'b0;
    end else begin
      poll_q <= 1'b0;
      case (state_q)
        CSC_ST_SLEEP: begin
          hold_run_q <= 1'b0;
          ind_q      <= 1'b0;
          if (!cyclic) begin
            per_cnt_q <= 12'h0;
          end else if (sleep_done || wake_pin) begin
            per_cnt_q  <= 12'h0;
            mult_cnt_q <= 16'h0;
            poll_q     <= 1'b1;
            state_q    <= CSC_ST_POLL;
            if (host_wake || wake_pin) begin
              ind_q      <= 1'b1;
              wake_cnt_q <= 16'h0;
            end else begin
              wake_cnt_q <= wake_cnt_q + 16'h1;
            end
            if (wake_pin || full_wake) begin
              hold_run_q <= 1'b1;
              hold_cnt_q <= hold_q;
            end
          end else if (per_done) begin
            per_cnt_q  <= 12'h0;
            mult_cnt_q <= mult_cnt_q + 16'h1;
          end else if (tick_q) begin
            per_cnt_q <= per_cnt_q + 12'h1;
          end
        end
        CSC_ST_POLL: begin
          // poll wake ends here when nothing keeps the device awake
          if (ack && pending) begin
            hold_run_q <= 1'b1;
            hold_cnt_q <= hold_q;
            poll_cnt_q <= 8'h0;
            state_q    <= CSC_ST_AWAKE;
          end else if (ack || data_in) begin
            poll_cnt_q <= 8'h0;
            state_q    <= (hold_run_q || data_in) ? CSC_ST_AWAKE : CSC_ST_SLEEP;
            if (data_in) begin
              hold_run_q <= 1'b1;
              hold_cnt_q <= hold_q;
            end
          end
          if (radio) begin
            ind_q <= 1'b1;
          end
          if (sleep_now_q) begin
            state_q <= CSC_ST_SLEEP;
          end
        end
        CSC_ST_AWAKE: begin
          if (data_in) begin
            hold_cnt_q <= hold_q;
            hold_run_q <= 1'b1;
          end else if (hold_run_q && tick_q) begin
            hold_cnt_q <= hold_cnt_q - 16'h1;
          end
          if (radio) begin
            ind_q <= 1'b1;
          end
          if (tick_q) begin
            if (poll_cnt_q >= 8'(CSC_POLL_TICKS - 1)) begin
              poll_cnt_q <= 8'h0;
              poll_q     <= 1'b1;
            end else begin
              poll_cnt_q <= poll_cnt_q + 8'h1;
            end
          end
          if (sleep_now_q || (hold_exp && !data_in) || !hold_run_q) begin
            state_q <= CSC_ST_SLEEP;
          end
        end
        default: state_q <= CSC_ST_SLEEP;
      endcase
    end
  end

  // clear-to-send only tracks awake when flow control is on
  logic cts_n_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cts_n_q <= 1'b1;
    end else begin
      cts_n_q <= ~(ctrl_q[CSC_CTRL_FLOW_BIT] & (state_q != CSC_ST_SLEEP));
    end
  end

  assign prdata_out    = prdata_q;
  assign pready_out    = pready_q;
  assign pslverr_out   = pslverr_q;
  assign poll_req_out  = poll_q;
  assign awake_ind_out = ind_q;
  assign cts_n_out     = cts_n_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_awake_sleep_now;
    (state_q == CSC_ST_AWAKE) && sleep_now_q;
  endsequence

  a_sleep_now_exit: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_awake_sleep_now |=> state_q == CSC_ST_SLEEP)
    else $error("sleep-now did not put device to sleep");

  a_period_range: assert property (@(posedge mclk_in) disable iff (rst_in)
    period_q >= CSC_PERIOD_MIN && period_q <= CSC_PERIOD_MAX)
    else $error("sleep period out of range");

  a_mult_nonzero: assert property (@(posedge mclk_in) disable iff (rst_in)
    mult_q != 16'h0)
    else $error("multiplier is zero");

  a_data_reload: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == CSC_ST_AWAKE) && data_in |=> hold_cnt_q == $past(hold_q))
    else $error("wake-hold timer not reloaded");

  a_ind_low_sleep: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == CSC_ST_SLEEP) && $past(state_q == CSC_ST_SLEEP) && !poll_q |-> !awake_ind_out)
    else $error("indicator high while asleep");

  a_radio_ind: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q != CSC_ST_SLEEP) && radio && !sleep_now_q |=> awake_ind_out)
    else $error("radio data did not raise indicator");

  a_wake_poll: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == CSC_ST_SLEEP) && cyclic && sleep_done |=> poll_q && state_q == CSC_ST_POLL)
    else $error("no poll after sleep period");

  a_tick_spacing: assert property (@(posedge mclk_in) disable iff (rst_in)
    tick_q |=> !tick_q)
    else $error("tick repeated");

  a_cts_follows: assert property (@(posedge mclk_in) disable iff (rst_in)
    !ctrl_q[CSC_CTRL_FLOW_BIT] && $stable(ctrl_q) |=> cts_n_out)
    else $error("clear-to-send low without flow control");

  a_hold_expiry: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == CSC_ST_AWAKE) && hold_exp && !data_in |=> state_q == CSC_ST_SLEEP)
    else $error("wake-hold expiry did not end the wake");

  a_silent_wake: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == CSC_ST_SLEEP) && cyclic && sleep_done && !host_wake && !wake_pin |=> !awake_ind_out)
    else $error("host woken on a silent poll");

endmodule // csc_sleep_ctrl

// >>> csc_parent_model.sv
`timescale 1ns/1ps
// network parent: acks every poll a few cycles later, pending flag set by the bench
module csc_parent_model (
  input  wire logic clk_in,
  input  wire logic poll_req_in,
  input  wire logic pending_in,
  output logic      ack_out,
  output logic      pending_out
);
  int cnt = 0;
  initial begin
    ack_out = 1'b0;
    pending_out = 1'b1;
  end
  always @(posedge clk_in) begin
    if (poll_req_in) cnt <= 1;
    else if (cnt != 0) cnt <= (cnt == 8) ? 0 : cnt + 1;
    ack_out <= (cnt >= 3);
    if (cnt == 3) pending_out <= pending_in;
    // no pull on the flag: once the ack is gone show the inverse, not a stale value
    if (ack_out && cnt < 3) pending_out <= ~pending_out;
  end
endmodule // csc_parent_model

// >>> cyclic_sleep_controller_tb.sv
`timescale 1ns/1ps
module cyclic_sleep_controller_tb;
  import csc_pkg::*;
  // short tick keeps every tested period between 640 and 1280 cycles
  localparam int TK = 20;
  localparam int HT = 16 * TK;
  logic        mclk_in  = 1'b0;
  logic        rst_in   = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic        pin      = 1'b1;
  logic        ser      = 1'b0;
  logic        rad      = 1'b0;
  logic        pend_cfg = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, ack, pend, poll, ind, cts_n;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  ////////////////////////
  csc_sleep_ctrl #(.TICK_CYC(TK)) DUT (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sleep_request_pin_in(pin),
    .serial_data_in(ser), .radio_data_in(rad), .poll_ack_in(ack), .poll_pending_in(pend),
    .poll_req_out(poll), .awake_ind_out(ind), .cts_n_out(cts_n));
  csc_parent_model parent (.clk_in(mclk_in), .poll_req_in(poll), .pending_in(pend_cfg),
    .ack_out(ack), .pending_out(pend));
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  ////////////////////////
  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic wrchk(input string nm, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    if (d !== 32'hffff_ffff) wr(a, d);
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic wpoll(output int t);
    do begin
      @(negedge mclk_in);
    end while (poll !== 1'b1);
    t = cyc;
  endtask
  task automatic wfall(output int n);
    n = 0;
    while (ind === 1'b1 && n < 3000) begin
      @(negedge mclk_in);
      n++;
    end
  endtask
  ////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    wrchk("period rst", CSC_OFF_PERIOD, 32'hffff_ffff, 32'h20);
    wrchk("mult rst", CSC_OFF_MULT, 32'hffff_ffff, 32'h1);
    wrchk("hold rst", CSC_OFF_HOLD, 32'hffff_ffff, 32'hc8);
    chk("ind rst", 32'h0, {31'h0, ind});
    chk("cts rst", 32'h1, {31'h0, cts_n});
    apb(1'b0, 12'h01c, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask
  task automatic t_limits();
    wrchk("period low", CSC_OFF_PERIOD, 32'h1f, 32'h20);
    wrchk("period max", CSC_OFF_PERIOD, 32'haf0, 32'haf0);
    wrchk("period high", CSC_OFF_PERIOD, 32'haf1, 32'haf0);
    wrchk("period min", CSC_OFF_PERIOD, 32'h20, 32'h20);
    wrchk("mult zero", CSC_OFF_MULT, 32'h0, 32'h1);
    wrchk("mult max", CSC_OFF_MULT, 32'hffff, 32'hffff);
    wrchk("mult one", CSC_OFF_MULT, 32'h1, 32'h1);
    wrchk("hold", CSC_OFF_HOLD, 32'h10, 32'h10);
  endtask
  task automatic t_short();
    int t0, t1;
    wr(CSC_OFF_CTRL, 32'h14);
    wpoll(t0);
    wpoll(t1);
    chk_rng("short period", 32 * TK - TK, 32 * TK + 4 * TK, t1 - t0);
    idle(2);
    chk("ind wake", 32'h1, {31'h0, ind});
    chk("cts wake", 32'h0, {31'h0, cts_n});
    idle(40);
    chk("ind no data", 32'h0, {31'h0, ind});
  endtask
  task automatic t_hold();
    int t0, t1, n;
    @(posedge mclk_in);
    pend_cfg <= 1'b1;
    wpoll(t0);
    idle(10);
    @(posedge mclk_in);
    pend_cfg <= 1'b0;
    wpoll(t1);
    chk_rng("awake poll gap", 10 * TK - TK, 10 * TK + TK, t1 - t0);
    @(posedge mclk_in);
    ser <= 1'b1;
    @(posedge mclk_in);
    ser <= 1'b0;
    idle(200);
    chk("ind awake", 32'h1, {31'h0, ind});
    @(posedge mclk_in);
    rad <= 1'b1;
    @(posedge mclk_in);
    rad <= 1'b0;
    wfall(n);
    chk_rng("hold reload", HT - TK, HT + TK + 10, n);
    chk("cts asleep", 32'h1, {31'h0, cts_n});
  endtask
  task automatic t_multi();
    int t, n, k;
    logic [2:0] s;
    wr(CSC_OFF_MULT, 32'h3);
    wpoll(t);
    for (k = 0; k < 3; k++) begin
      wpoll(t);
      idle(3);
      s[k] = ind;
    end
    chk("one loud wake of three", 32'h1, 32'(s[0]) + 32'(s[1]) + 32'(s[2]));
    // wake three after a loud one is loud again, so skip it
    if (s[0] === 1'b1) wpoll(t);
    wpoll(t);
    @(posedge mclk_in);
    rad <= 1'b1;
    n = 0;
    while (ind !== 1'b1 && n < 50) begin
      @(negedge mclk_in);
      n++;
    end
    chk_rng("radio raises ind", 1, 8, n);
    @(posedge mclk_in);
    rad <= 1'b0;
    wr(CSC_OFF_CMD, 32'h1);
    wfall(n);
    chk_rng("sleep now", 0, 4, n);
  endtask
  task automatic t_ext();
    int t0, t1, n;
    wr(CSC_OFF_MULT, 32'h2);
    wr(CSC_OFF_OPT, 32'h4);
    wpoll(t0);
    wpoll(t1);
    chk_rng("extended period", 64 * TK - TK, 64 * TK + 4 * TK, t1 - t0);
    wr(CSC_OFF_OPT, 32'h6);
    wpoll(t0);
    idle(2);
    wfall(n);
    chk_rng("full wake", HT - TK, HT + TK + 10, n);
  endtask
  task automatic t_pin();
    int t0, t1, n;
    wr(CSC_OFF_OPT, 32'h0);
    wr(CSC_OFF_MULT, 32'h1);
    wr(CSC_OFF_CTRL, 32'h15);
    wpoll(t0);
    idle(100);
    @(posedge mclk_in);
    pin <= 1'b0;
    t0 = cyc;
    wpoll(t1);
    chk_rng("pin wake", 1, 8, t1 - t0);
    idle(2);
    wfall(n);
    chk_rng("pin hold", HT - TK, HT + TK + 10, n);
    @(posedge mclk_in);
    pin <= 1'b1;
  endtask
  ////////////////////////
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_limits();
    t_short();
    t_hold();
    t_multi();
    t_ext();
    t_pin();
    complete_run();
  end
endmodule // cyclic_sleep_controller_tb
